/* File: design/miep_top.sv */
`timescale 1ns/1ps
module miep_top
(
    input  wire logic                                          I_SYS_CLK,
    input  wire logic                                          I_RST,
    input  wire logic [miep_pkg::ADDR_W-1:0]                   I_SFR_ADDR,
    input  wire logic                                          I_SFR_WR,
    input  wire logic                                          I_SFR_RD,
    input  wire logic [miep_pkg::DATA_W-1:0]                   I_SFR_WDATA,
    input  wire logic [miep_pkg::NSRC-1:0]                     I_REQ_LATCH,
    input  wire logic                                          I_NMI_REQ,
    input  wire logic                                          I_ACCEPT,
    input  wire logic                                          I_UNMASK_ALL,
    input  wire logic                                          I_MASK_ALL,
    input  wire logic                                          I_RETURN,
    input  wire logic                                          I_RETURN_IMF,
    output logic      [miep_pkg::DATA_W-1:0]                   O_SFR_RDATA,
    output logic                                               O_SFR_HIT,
    output logic                                               O_IRQ_VALID,
    output logic      [miep_pkg::ID_W-1:0]                     O_IRQ_ID,
    output logic      [miep_pkg::LVL_W-1:0]                    O_IRQ_LEVEL,
    output logic                                               O_NMI_VALID,
    output logic                                               O_MASTER_EN,
    output logic      [miep_pkg::NSRC-1:0]                     O_SRC_ENABLE,
    output logic      [miep_pkg::NLVL_SRC*miep_pkg::LVL_W-1:0] O_SRC_LEVEL
);
    import miep_pkg::*;

    miep_state_t st_r;
    miep_state_t st_nxt;

    // per-source level, sources 20 to 25 have no field and sit at level 0
    logic [LVL_W-1:0] src_lvl [NSRC];
    logic [NSRC-1:0]  cand;

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            if (g < NLVL_SRC)
            begin : g_lvl
                assign src_lvl[g] = st_r.lvl[g*LVL_W +: LVL_W];
            end
            else
            begin : g_nolvl
                assign src_lvl[g] = RST_LVL;
            end
            assign cand[g] = I_REQ_LATCH[g] & st_r.en[g];
        end
    endgenerate

    // byte index of a level register, or -1 when the address is not one
    function automatic int lvl_reg_idx(input logic [ADDR_W-1:0] a);
        int r;
        r = -1;
        unique case (a)
            ADDR_LVL_A: r = 0;
            ADDR_LVL_B: r = 1;
            ADDR_LVL_C: r = 2;
            ADDR_LVL_D: r = 3;
            default:    r = -1;
        endcase
        return r;
    endfunction : lvl_reg_idx

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic m;
        m = (a == ADDR_EN_LOW) || (a == ADDR_EN_HIGH) ||
            (a == ADDR_EN_EXT) || (a == ADDR_EN_TOP) ||
            (lvl_reg_idx(a) >= 0);
        return m;
    endfunction : is_mapped

    // read image of one register; unused bits stay zero
    function automatic logic [DATA_W-1:0] read_reg(
        input logic [ADDR_W-1:0]           a,
        input logic                        master_irq_enable,
        input logic [NSRC-1:0]             en,
        input logic [NLVL_SRC*LVL_W-1:0]   lvl
    );
        logic [DATA_W-1:0] d;
        int                k;
        d = RST_BYTE;
        k = lvl_reg_idx(a);
        if (a == ADDR_EN_LOW)
        begin
            d[IMF_BIT] = master_irq_enable;
            d[EN_LOW_LSB +: EN_LOW_CNT] = en[0 +: EN_LOW_CNT];
        end
        else if (a == ADDR_EN_HIGH)
        begin
            d = en[EN_LOW_CNT +: DATA_W];
        end
        else if (a == ADDR_EN_EXT)
        begin
            d = en[EN_LOW_CNT+DATA_W +: DATA_W];
        end
        else if (a == ADDR_EN_TOP)
        begin
            d[0 +: EN_TOP_CNT] = en[EN_LOW_CNT+2*DATA_W +: EN_TOP_CNT];
        end
        else if (k >= 0)
        begin
            d = lvl[k*DATA_W +: DATA_W];
        end
        return d;
    endfunction : read_reg

    // highest level wins; scanning down with >= lets the lowest source win ties
    function automatic logic [ID_W+LVL_W:0] pick(
        input logic [NSRC-1:0] c,
        input logic [NSRC*LVL_W-1:0] l
    );
        logic             found;
        logic [ID_W-1:0]  best_idx;
        logic [LVL_W-1:0] best_lvl;
        found    = 1'b0;
        best_idx = '0;
        best_lvl = RST_LVL;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (c[i] && (!found || l[i*LVL_W +: LVL_W] >= best_lvl))
            begin
                found    = 1'b1;
                best_idx = ID_W'(i);
                best_lvl = l[i*LVL_W +: LVL_W];
            end
        end
        return {found, best_idx, best_lvl};
    endfunction : pick

    logic [NSRC*LVL_W-1:0]  lvl_flat;
    logic [ID_W+LVL_W:0]    win;
    logic                   win_found;
    logic [ID_W-1:0]        win_idx;
    logic [LVL_W-1:0]       win_lvl;

    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            lvl_flat[i*LVL_W +: LVL_W] = src_lvl[i];
        end
    end

    assign win       = pick(cand, lvl_flat);
    assign win_found = win[ID_W+LVL_W];
    assign win_idx   = win[LVL_W +: ID_W];
    assign win_lvl   = win[0 +: LVL_W];

    always_comb
    begin
        int k;
        k      = lvl_reg_idx(I_SFR_ADDR);
        st_nxt = st_r;

        // register writes
        if (I_SFR_WR)
        begin
            if (I_SFR_ADDR == ADDR_EN_LOW)
            begin
                st_nxt.master_irq_enable = I_SFR_WDATA[IMF_BIT];
                st_nxt.en[0 +: EN_LOW_CNT] = I_SFR_WDATA[EN_LOW_LSB +: EN_LOW_CNT];
            end
            else if (I_SFR_ADDR == ADDR_EN_HIGH)
            begin
                st_nxt.en[EN_LOW_CNT +: DATA_W] = I_SFR_WDATA;
            end
            else if (I_SFR_ADDR == ADDR_EN_EXT)
            begin
                st_nxt.en[EN_LOW_CNT+DATA_W +: DATA_W] = I_SFR_WDATA;
            end
            else if (I_SFR_ADDR == ADDR_EN_TOP)
            begin
                st_nxt.en[EN_LOW_CNT+2*DATA_W +: EN_TOP_CNT] = I_SFR_WDATA[0 +: EN_TOP_CNT];
            end
            else if (k >= 0)
            begin
                st_nxt.lvl[k*DATA_W +: DATA_W] = I_SFR_WDATA;
            end
        end

        // master enable instructions override a same-cycle register write
        if (I_MASK_ALL)
        begin
            st_nxt.master_irq_enable = 1'b0;
        end
        else if (I_UNMASK_ALL)
        begin
            st_nxt.master_irq_enable = 1'b1;
        end

        // return reloads the stacked value
        if (I_RETURN)
        begin
            st_nxt.master_irq_enable = I_RETURN_IMF;
        end

        // acceptance clears last so a handler always starts masked
        if (I_ACCEPT)
        begin
            st_nxt.master_irq_enable = 1'b0;
        end

        // reads return the value before any same-cycle write
        if (I_SFR_RD)
        begin
            st_nxt.rdata = read_reg(I_SFR_ADDR, st_r.master_irq_enable, st_r.en, st_r.lvl);
            st_nxt.hit   = is_mapped(I_SFR_ADDR);
        end
        else
        begin
            st_nxt.rdata = RST_BYTE;
            st_nxt.hit   = 1'b0;
        end

        // request toward the sequencer; dropped in the accept cycle
        st_nxt.irq_valid = st_r.master_irq_enable && win_found && !I_ACCEPT;
        st_nxt.irq_id    = win_found ? ID_W'(win_idx + ID_W'(SRC_FIRST)) : '0;
        st_nxt.irq_lvl   = win_found ? win_lvl : RST_LVL;

        st_nxt.nmi_valid = I_NMI_REQ;
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            st_r.master_irq_enable       <= 1'b0;
            st_r.en        <= '0;
            st_r.lvl       <= '0;
            st_r.rdata     <= RST_BYTE;
            st_r.hit       <= 1'b0;
            st_r.irq_valid <= 1'b0;
            st_r.irq_id    <= '0;
            st_r.irq_lvl   <= RST_LVL;
            st_r.nmi_valid <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign O_SFR_RDATA  = st_r.rdata;
    assign O_SFR_HIT    = st_r.hit;
    assign O_IRQ_VALID  = st_r.irq_valid;
    assign O_IRQ_ID     = st_r.irq_id;
    assign O_IRQ_LEVEL  = st_r.irq_lvl;
    assign O_NMI_VALID  = st_r.nmi_valid;
    assign O_MASTER_EN  = st_r.master_irq_enable;
    assign O_SRC_ENABLE = st_r.en;
    assign O_SRC_LEVEL  = st_r.lvl;
endmodule : miep_top

/* File: design/miep_pkg.sv */
//Contract
//- master enable at low enable register bit 0 gates all maskable acceptance.
//- one enable bit per source 4 to 25 allows or blocks that source.
//- unused bits of the enable registers read back as zero.
//- each source 4 to 25 gets one of four levels over its basic priority; only sources 4 to 19 have a level field, 20 to 25 sit at level 0.
//- level field 00 lowest to 11 highest; larger level served first.
//- ties at one level go to the higher basic priority.
//- only individually enabled requests enter the selection.
//- after reset every level field is zero.
//- first level register holds sources 7,6,5,4 from top bits down.
//- second level register holds sources 11,10,9,8 from top bits down.
//- third level register holds sources 15,14,13,12 from top bits down.
//- fourth level register holds sources 19,18,17,16 from top bits down.
//- accepting an interrupt clears the master enable automatically.
//- non-maskable sources bypass master and individual enables.
//- reset clears all individual enable bits.
//- reset clears the master enable bit.
package miep_pkg;
    localparam int          SRC_FIRST     = 4;
    localparam int          SRC_LAST      = 25;
    localparam int          NSRC          = SRC_LAST - SRC_FIRST + 1;
    localparam int          NLVL_SRC      = 16;
    localparam int          LVL_W         = 2;
    localparam int          ID_W          = 5;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;
    localparam int          FIELDS_PER_REG = 4;
    localparam logic [11:0] ADDR_EN_LOW   = 12'h03A;
    localparam logic [11:0] ADDR_EN_HIGH  = 12'h03B;
    localparam logic [11:0] ADDR_EN_EXT   = 12'h03C;
    localparam logic [11:0] ADDR_EN_TOP   = 12'h03D;
    localparam logic [11:0] ADDR_LVL_A    = 12'hFF0;
    localparam logic [11:0] ADDR_LVL_B    = 12'hFF1;
    localparam logic [11:0] ADDR_LVL_C    = 12'hFF2;
    localparam logic [11:0] ADDR_LVL_D    = 12'hFF3;
    localparam int          IMF_BIT       = 0;
    localparam int          EN_LOW_LSB    = 4;
    localparam int          EN_LOW_CNT    = 4;
    localparam int          EN_TOP_CNT    = 2;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [1:0]  RST_LVL       = 2'h0;

    typedef struct packed {
        logic                      master_irq_enable;
        logic [NSRC-1:0]           en;
        logic [NLVL_SRC*LVL_W-1:0] lvl;
        logic [DATA_W-1:0]         rdata;
        logic                      hit;
        logic                      irq_valid;
        logic [ID_W-1:0]           irq_id;
        logic [LVL_W-1:0]          irq_lvl;
        logic                      nmi_valid;
    } miep_state_t;
endpackage : miep_pkg

/* File: bench/miep_chk.sv */
`timescale 1ns/1ps
module miep_chk
(
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST,
    input wire logic [11:0] I_SFR_ADDR,
    input wire logic        I_SFR_WR,
    input wire logic        I_SFR_RD,
    input wire logic [7:0]  I_SFR_WDATA,
    input wire logic        I_NMI_REQ,
    input wire logic        I_ACCEPT,
    input wire logic        I_UNMASK_ALL,
    input wire logic        I_MASK_ALL,
    input wire logic        I_RETURN,
    input wire logic [7:0]  O_SFR_RDATA,
    input wire logic        O_IRQ_VALID,
    input wire logic [4:0]  O_IRQ_ID,
    input wire logic        O_NMI_VALID,
    input wire logic        O_MASTER_EN,
    input wire logic [21:0] O_SRC_ENABLE,
    input wire logic [31:0] O_SRC_LEVEL
);
    logic [21:0] en_q;
    // enables as seen by the selector one edge earlier
    always_ff @(posedge I_SYS_CLK) en_q <= O_SRC_ENABLE;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence s_masked;
        !O_MASTER_EN && !O_IRQ_VALID;
    endsequence
    a_accept_masks: assert property (I_ACCEPT |=> s_masked) else $error("accept left unmasked");
    a_unmask_sets: assert property (I_UNMASK_ALL && !I_MASK_ALL && !I_RETURN && !I_ACCEPT |=> O_MASTER_EN)
        else $error("unmask ignored");
    a_valid_gated: assert property (O_IRQ_VALID |-> $past(O_MASTER_EN)) else $error("offer while masked");
    a_valid_enabled: assert property (O_IRQ_VALID |-> en_q[O_IRQ_ID - 5'd4]) else $error("disabled winner");
    a_reset_clear: assert property ($fell(I_RST) |-> !O_MASTER_EN && O_SRC_ENABLE == 0 && O_SRC_LEVEL == 0)
        else $error("state after reset");
    a_low_unused: assert property (I_SFR_RD && I_SFR_ADDR == 12'h03A |=> O_SFR_RDATA[3:1] == 3'h0)
        else $error("unused bits set");
    a_en_write: assert property (I_SFR_WR && I_SFR_ADDR == 12'h03B |=> O_SRC_ENABLE[11:4] == $past(I_SFR_WDATA))
        else $error("enable write lost");
    a_lvl_write: assert property (I_SFR_WR && I_SFR_ADDR == 12'hFF3 |=> O_SRC_LEVEL[31:24] == $past(I_SFR_WDATA))
        else $error("level write lost");
    a_nmi_pass: assert property (I_NMI_REQ |=> O_NMI_VALID) else $error("nmi blocked");
endmodule : miep_chk

/* File: bench/miep_seq_model.sv */
`timescale 1ns/1ps
module miep_seq_model
(
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [3:0] i_dly,
    input  wire logic       i_req,
    input  wire logic [4:0] i_id,
    output logic            o_accept,
    output logic [4:0]      o_took
);
    logic [3:0] cnt = 4'h0;
    initial o_accept = 1'b0;
    initial o_took = 5'h00;
    // waits i_dly cycles so both prompt and slow acceptance are exercised
    always @(negedge i_clk)
    begin
        o_accept <= 1'b0;
        if (!i_go || o_accept)
            cnt <= 4'h0;
        else if (i_req && cnt == i_dly)
        begin
            o_accept <= 1'b1;
            o_took <= i_id;
        end
        else if (i_req)
            cnt <= cnt + 4'h1;
    end
endmodule : miep_seq_model

/* File: bench/test_maskable_irq_enable_priority.sv */
`timescale 1ns/1ps
module test_maskable_irq_enable_priority;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  wd = 8'h00;
    logic [21:0] lt = '0;
    logic        nmi = 1'b0;
    logic [2:0]  c = 3'h0;
    logic        go = 1'b0;
    logic [3:0]  dly = 4'h3;
    logic        rim = 1'b1;
    logic [1:0]  lvo;
    logic        acc;
    logic        hit;
    logic        iv;
    logic        nv;
    logic        men;
    logic [4:0]  id;
    logic [4:0]  took;
    logic [7:0]  rdat;
    logic [21:0] sen;
    logic [31:0] slv;
    int          bad_count = 0;
    int          num_checks = 0;
    int          n;
    logic [11:0] am [9] = '{12'h03A, 12'h03B, 12'h03C, 12'h03D, 12'hFF0, 12'hFF1, 12'hFF2, 12'hFF3, 12'hFF4};
    logic [7:0]  wv [9] = '{8'hFE, 8'hA5, 8'h5A, 8'hFF, 8'h1B, 8'hE4, 8'h39, 8'hC6, 8'h77};
    logic [7:0]  rv [9] = '{8'hF0, 8'hA5, 8'h5A, 8'h03, 8'h1B, 8'hE4, 8'h39, 8'hC6, 8'h00};
    always #10 clk = ~clk;
    miep_top u_miep_top (.I_SYS_CLK(clk), .I_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd),
        .I_SFR_WDATA(wd), .I_REQ_LATCH(lt), .I_NMI_REQ(nmi), .I_ACCEPT(acc), .I_UNMASK_ALL(c[0]),
        .I_MASK_ALL(c[1]), .I_RETURN(c[2]), .I_RETURN_IMF(rim), .O_SFR_RDATA(rdat), .O_SFR_HIT(hit),
        .O_IRQ_VALID(iv), .O_IRQ_ID(id), .O_IRQ_LEVEL(lvo), .O_NMI_VALID(nv), .O_MASTER_EN(men),
        .O_SRC_ENABLE(sen), .O_SRC_LEVEL(slv));
    miep_seq_model u_miep_seq_model (.i_clk(clk), .i_go(go), .i_dly(dly), .i_req(iv | nv), .i_id(id),
        .o_accept(acc), .o_took(took));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        {wr, rd, addr, wd} = {w, !w, a, d};
        @(negedge clk);
        {wr, rd} = 2'b00;
    endtask : bus
    task automatic rd_reg(input logic [11:0] a, input logic [7:0] e, input logic eh);
        bus(1'b0, a, 8'h00);
        chk("rdata", rdat, e);
        chk("hit", hit, eh);
    endtask : rd_reg
    task automatic ctl(input logic [2:0] v);
        @(negedge clk);
        c = v;
        @(negedge clk);
        c = 3'h0;
    endtask : ctl
    task automatic t_reset;
        for (int i = 0; i < 9; i++) rd_reg(am[i], 8'h00, i < 8);
    endtask : t_reset
    task automatic t_regs;
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, am[i], wv[i]);
            rd_reg(am[i], rv[i], i < 8);
        end
        chk("levels", slv, 32'hC639E41B);
        chk("enables", sen, {2'b11, 8'h5A, 8'hA5, 4'hF});
    endtask : t_regs
    task automatic arb(input logic [11:0] la, input logic [7:0] lv, input logic [11:0] ea, input logic [7:0] ev,
            input logic [21:0] l, input logic um, input logic xv, input logic [4:0] xid, input logic [1:0] xl);
        ctl(3'h2);
        bus(1'b1, la, lv);
        bus(1'b1, ea, ev);
        lt = l;
        if (um)
            ctl(3'h1);
        repeat (2) @(negedge clk);
        chk("valid", iv, xv);
        chk("id", id, xid);
        chk("level", lvo, xl);
    endtask : arb
    task automatic t_take(input logic [4:0] xid);
        // non-blocking so the model, which samples on the same edge, sees a stable value
        go <= 1'b1;
        for (n = 0; n < 20 && acc !== 1'b1; n++) @(posedge clk);
        @(negedge clk);
        go <= 1'b0;
        if (n == 20)
            bad_count++;
        if (n == 20)
            final_report;
        chk("master", men, 1'b0);
        chk("taken", took, xid);
    endtask : t_take
    task automatic t_renest;
        bus(1'b1, 12'h03C, 8'h10);
        ctl(3'h1);
        @(negedge clk);
        chk("renest", iv, 1'b1);
        chk("renest_id", id, 5'd20);
        rim = 1'b0;
        ctl(3'h4);
        @(negedge clk);
        chk("ret0", men, 1'b0);
        chk("ret0_valid", iv, 1'b0);
        rim = 1'b1;
        ctl(3'h4);
        @(negedge clk);
        chk("ret1", men, 1'b1);
        chk("ret1_valid", iv, 1'b1);
    endtask : t_renest
    task automatic t_nmi;
        ctl(3'h2);
        nmi = 1'b1;
        dly <= 4'h0;
        @(negedge clk);
        chk("nmi", nv, 1'b1);
        t_take(20);
    endtask : t_nmi
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_regs;
        arb(12'hFF0, 8'hC0, 12'h03A, 8'h90, 22'h9, 1, 1, 7, 2'h3);
        arb(12'hFF0, 8'h00, 12'h03A, 8'h90, 22'h9, 1, 1, 4, 2'h0);
        arb(12'hFF0, 8'h00, 12'h03A, 8'h80, 22'h9, 1, 1, 7, 2'h0);
        arb(12'hFF0, 8'h4C, 12'h03A, 8'hA0, 22'hA, 1, 1, 5, 2'h3);
        arb(12'hFF0, 8'h80, 12'h03A, 8'hC0, 22'hC, 1, 1, 7, 2'h2);
        arb(12'hFF0, 8'hC0, 12'h03A, 8'h90, 22'h9, 0, 0, 7, 2'h3);
        arb(12'hFF3, 8'hC0, 12'h03C, 8'h18, 22'h18000, 1, 1, 19, 2'h3);
        arb(12'hFF3, 8'h00, 12'h03C, 8'h18, 22'h18000, 1, 1, 19, 2'h0);
        t_take(19);
        t_renest;
        t_nmi;
        nmi = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset;
        final_report;
    end
endmodule : test_maskable_irq_enable_priority
bind miep_top miep_chk u_miep_chk (.*);
